// ==== verilog/wtpg_pkg.sv ====
`default_nettype none
package wtpg_pkg;
  localparam int DAC_W = 14;
  localparam int NREG = 13;

  // register indices into the shadow and active sets
  localparam int IX_OFFSET = 0;
  localparam int IX_WAVE = 1;
  localparam int IX_TIMEBASE = 2;
  localparam int IX_PERIOD = 3;
  localparam int IX_REPEAT = 4;
  localparam int IX_SB_START = 5;
  localparam int IX_SB_CFG = 6;
  localparam int IX_CONST = 7;
  localparam int IX_GAIN = 8;
  localparam int IX_RAMP = 9;
  localparam int IX_REPLAY = 10;
  localparam int IX_PAT_DLY = 11;
  localparam int IX_START_DLY = 12;

  localparam logic [7:0] A_UPDATE = 8'h1D;
  localparam logic [7:0] A_STATUS = 8'h1E;
  localparam logic [NREG-1:0][7:0] REG_ADDR = {
    8'h5C, 8'h20, 8'h1F, 8'h37, 8'h35, 8'h31, 8'h2D, 8'h2C, 8'h2B, 8'h29, 8'h28, 8'h27, 8'h25};
  localparam logic [NREG-1:0][15:0] REG_RESET = {
    16'h0000, 16'h000E, 16'h0000, 16'h0104, 16'h0000, 16'h0000, 16'h0000,
    16'h0003, 16'h0101, 16'h8000, 16'h0111, 16'h0101, 16'h0000};

  // field positions
  localparam int UPD_BIT = 0;
  localparam int STAT_PLAY_BIT = 1;
  localparam int REPLAY_BIT = 0;
  localparam int WSEL_LSB = 0;
  localparam int WSEL_W = 2;
  localparam int CHADD_BIT = 2;
  localparam int SRC_LSB = 4;
  localparam int SRC_W = 2;
  localparam int HOLD_LSB = 8;
  localparam int PBASE_LSB = 4;
  localparam int DBASE_LSB = 0;
  localparam int BASE_W = 4;
  localparam int REP_LSB = 0;
  localparam int REP_W = 8;
  localparam int SSTOP_LSB = 0;
  localparam int SSTOP_W = 4;
  localparam int SMODE_BIT = 4;
  localparam int SVAL_BIT = 5;
  localparam int VAL12_LSB = 4;
  localparam int VAL12_W = 12;
  localparam int RTYPE_LSB = 0;
  localparam int RTYPE_W = 2;
  localparam int RSTEP_LSB = 2;
  localparam int RSTEP_W = 6;

  localparam logic [1:0] WAVE_RAM = 2'h0;
  localparam logic [1:0] WAVE_BUILTIN = 2'h1;
  localparam logic [1:0] WAVE_GATED = 2'h2;
  localparam logic [1:0] WAVE_MOD = 2'h3;
  localparam logic [1:0] SRC_CONST = 2'h0;
  localparam logic [1:0] SRC_RAMP = 2'h1;
  localparam logic [1:0] SRC_PRBS = 2'h2;
  localparam logic [1:0] SRC_DDS = 2'h3;
  localparam logic [1:0] RAMP_UP = 2'h0;
  localparam logic [1:0] RAMP_DOWN = 2'h1;
  localparam logic [1:0] RAMP_TRI = 2'h2;

  localparam int GAIN_FRAC = 10;
  localparam int MOD_FRAC = 13;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  localparam logic [13:0] RAMP_TOP = 14'h3FFF;
  localparam logic signed [16:0] SAT_MAX = 17'sh0_1FFF;
  localparam logic signed [16:0] SAT_MIN = -17'sh0_2000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_PLAY = 2'b10
  } wtpg_state_t;

  function automatic logic [DAC_W-1:0] wtpg_sat(input logic signed [16:0] v);
    logic [DAC_W-1:0] r;
    r = v[DAC_W-1:0];
    if (v > SAT_MAX)
    begin
      r = SAT_MAX[DAC_W-1:0];
    end
    else if (v < SAT_MIN)
    begin
      r = SAT_MIN[DAC_W-1:0];
    end
    return r;
  endfunction : wtpg_sat
endpackage : wtpg_pkg
`default_nettype wire

// ==== verilog/wtpg_tick_div.sv ====
`default_nettype none
module wtpg_tick_div
  import wtpg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic clear_i,
  input wire logic [BASE_W-1:0] limit_i,
  // one-cycle enable every limit_i plus one clocks
  output logic tick_o
);
  typedef struct packed {
    logic [BASE_W-1:0] cnt;
  } wtpg_div_t;

  wtpg_div_t q;
  wtpg_div_t n;

  always_comb
  begin
    n = q;
    if (clear_i || (q.cnt == limit_i))
    begin
      n.cnt = '0;
    end
    else
    begin
      n.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  assign tick_o = !clear_i && (q.cnt == limit_i);
endmodule : wtpg_tick_div
`default_nettype wire

// ==== verilog/wtpg_core.sv ====
`default_nettype none
module wtpg_core
  import wtpg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // trigger pin and strobe on the shared data pin
  input wire logic trigger_n_i,
  input wire logic strobe_enable_i,
  output logic sdo_strobe_o,
  output logic sdo_strobe_oe_n_o,
  // pattern memory
  input wire logic [11:0] ram_start_addr_i,
  input wire logic [11:0] ram_stop_addr_i,
  input wire logic [DAC_W-1:0] ram_data_i,
  output logic [11:0] ram_addr_o,
  // other sample sources
  input wire logic [DAC_W-1:0] dds_data_i,
  input wire logic [DAC_W-1:0] chan_sum_i,
  // converter side
  output logic [DAC_W-1:0] dac_data_o,
  output logic pattern_active_o
);
  typedef struct packed {
    logic [NREG-1:0][15:0] shadow;
    logic [NREG-1:0][15:0] active;
    logic upd;
    wtpg_state_t st;
    logic trig_s1;
    logic trig_s2;
    logic trig_prev;
    logic [15:0] dly_cnt;
    logic [15:0] per_cnt;
    logic [15:0] sd_cnt;
    logic [7:0] rep_cnt;
    logic [11:0] ram_addr;
    logic [13:0] ramp;
    logic ramp_down;
    logic [5:0] step_cnt;
    logic [15:0] lfsr;
    logic strobe_auto;
    logic sb_arm;
    logic [15:0] sb_cnt;
    logic sp_arm;
    logic [3:0] sp_cnt;
    logic pin;
    logic [DAC_W-1:0] dac;
    logic [15:0] rdata;
  } wtpg_core_t;

  wtpg_core_t q;
  wtpg_core_t n;
  wtpg_core_t q_reset;

  logic sample_tick;
  logic period_tick;
  logic delay_tick;
  logic playing;
  logic trig_fall;
  logic pat_end;
  logic pat_done;
  logic gate_open;
  logic [1:0] wave_sel;
  logic [1:0] src_sel;
  logic [1:0] ramp_shape;
  logic [5:0] ramp_step_length;
  logic signed [DAC_W-1:0] builtin;
  logic signed [DAC_W-1:0] ram_s;
  logic signed [DAC_W-1:0] ramp_s;
  logic signed [DAC_W-1:0] samp;
  logic signed [DAC_W-1:0] summed;
  logic signed [27:0] mod_prod;
  logic signed [25:0] gain_prod;
  logic signed [11:0] gain_f;
  logic signed [16:0] scaled;
  logic signed [16:0] off_ext;
  logic signed [16:0] ch_sum;

  assign playing = (q.st == ST_PLAY);
  assign trig_fall = q.trig_prev && !q.trig_s2;
  assign wave_sel = q.active[IX_WAVE][WSEL_LSB +: WSEL_W];
  assign src_sel = q.active[IX_WAVE][SRC_LSB +: SRC_W];
  assign ramp_shape = q.active[IX_RAMP][RTYPE_LSB +: RTYPE_W];
  assign ramp_step_length = q.active[IX_RAMP][RSTEP_LSB +: RSTEP_W];
  assign ram_s = ram_data_i;
  assign gate_open = (q.sd_cnt >= q.active[IX_START_DLY]);

  // one divider per timebase; all restart when a pattern starts
  wtpg_tick_div u_hold_div (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(!playing),
    .limit_i(q.active[IX_TIMEBASE][HOLD_LSB +: BASE_W]),
    .tick_o(sample_tick)
  );

  wtpg_tick_div u_period_div (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(!playing),
    .limit_i(q.active[IX_TIMEBASE][PBASE_LSB +: BASE_W]),
    .tick_o(period_tick)
  );

  wtpg_tick_div u_delay_div (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(!playing),
    .limit_i(q.active[IX_TIMEBASE][DBASE_LSB +: BASE_W]),
    .tick_o(delay_tick)
  );

  // period of zero wraps and so lasts the full 65536 units
  assign pat_end = playing && period_tick && (q.per_cnt == q.active[IX_PERIOD] - 16'h0001);
  assign pat_done = pat_end && q.active[IX_REPLAY][REPLAY_BIT]
                    && (q.rep_cnt == q.active[IX_REPEAT][REP_LSB +: REP_W]);

  // sample path
  always_comb
  begin
    ramp_s = {~q.ramp[DAC_W-1], q.ramp[DAC_W-2:0]};
    case (src_sel)
      SRC_CONST: builtin = {q.active[IX_CONST][VAL12_LSB +: VAL12_W], 2'b00};
      SRC_RAMP: builtin = (ramp_shape == RAMP_TRI + 2'h1) ? '0 : ramp_s;
      SRC_PRBS: builtin = q.lfsr[DAC_W-1:0];
      SRC_DDS: builtin = dds_data_i;
      default: builtin = '0;
    endcase
    mod_prod = builtin * ram_s;
    case (wave_sel)
      WAVE_RAM: samp = ram_s;
      WAVE_BUILTIN: samp = builtin;
      WAVE_GATED: samp = gate_open ? builtin : '0;
      WAVE_MOD: samp = mod_prod[MOD_FRAC +: DAC_W];
      default: samp = '0;
    endcase
    if (!playing)
    begin
      samp = '0;
    end
    ch_sum = 17'(samp) + 17'(signed'(chan_sum_i));
    if (q.active[IX_WAVE][CHADD_BIT])
    begin
      summed = wtpg_sat(ch_sum);
    end
    else
    begin
      summed = samp;
    end
    gain_f = q.active[IX_GAIN][VAL12_LSB +: VAL12_W];
    gain_prod = summed * gain_f;
    // part-select drops the sign, so restore it before widening
    scaled = 17'(signed'(gain_prod[GAIN_FRAC +: 16]));
    off_ext = 17'(signed'({q.active[IX_OFFSET][VAL12_LSB +: VAL12_W], 2'b00}));
  end

  always_comb
  begin
    q_reset = '0;
    q_reset.shadow = REG_RESET;
    q_reset.active = REG_RESET;
    q_reset.st = ST_IDLE;
    q_reset.trig_s1 = 1'b1;
    q_reset.trig_s2 = 1'b1;
    q_reset.trig_prev = 1'b1;
    q_reset.lfsr = LFSR_SEED;
  end

  always_comb
  begin
    n = q;
    n.trig_s1 = trigger_n_i;
    n.trig_s2 = q.trig_s1;
    n.trig_prev = q.trig_s2;

    // settings: clear the update first so a new request in the same cycle wins
    if (q.upd)
    begin
      n.active = q.shadow;
      n.upd = 1'b0;
    end
    if (reg_wr_i)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        if (reg_addr_i == REG_ADDR[i])
        begin
          n.shadow[i] = reg_wdata_i;
        end
      end
      if ((reg_addr_i == A_UPDATE) && reg_wdata_i[UPD_BIT])
      begin
        n.upd = 1'b1;
      end
    end
    if (reg_rd_i)
    begin
      n.rdata = '0;
      for (int i = 0; i < NREG; i++)
      begin
        if (reg_addr_i == REG_ADDR[i])
        begin
          n.rdata = q.shadow[i];
        end
      end
      if (reg_addr_i == A_UPDATE)
      begin
        n.rdata[UPD_BIT] = q.upd;
      end
      if (reg_addr_i == A_STATUS)
      begin
        n.rdata[STAT_PLAY_BIT] = playing;
      end
    end

    // pattern sequencer
    case (q.st)
      ST_IDLE:
      begin
        if (trig_fall)
        begin
          n.st = ST_DELAY;
          n.dly_cnt = '0;
        end
      end
      ST_DELAY:
      begin
        if (q.dly_cnt == q.active[IX_PAT_DLY])
        begin
          n.st = ST_PLAY;
          n.per_cnt = '0;
          n.sd_cnt = '0;
          n.rep_cnt = '0;
          n.step_cnt = '0;
          n.ram_addr = ram_start_addr_i;
        end
        else
        begin
          n.dly_cnt = q.dly_cnt + 16'h0001;
        end
      end
      ST_PLAY:
      begin
        if (period_tick)
        begin
          n.per_cnt = q.per_cnt + 16'h0001;
        end
        if (delay_tick && !gate_open)
        begin
          n.sd_cnt = q.sd_cnt + 16'h0001;
        end
        if (pat_end)
        begin
          n.per_cnt = '0;
          n.sd_cnt = '0;
          n.rep_cnt = q.rep_cnt + 8'h01;
          if (pat_done)
          begin
            n.st = ST_IDLE;
          end
        end
        if (sample_tick)
        begin
          n.lfsr = {q.lfsr[14:0], ^(q.lfsr & LFSR_TAPS)};
          n.ram_addr = (q.ram_addr == ram_stop_addr_i) ? ram_start_addr_i
                       : q.ram_addr + 12'h001;
          if ({1'b0, q.step_cnt} + 7'h01 >= {1'b0, ramp_step_length})
          begin
            n.step_cnt = '0;
            case (ramp_shape)
              RAMP_UP: n.ramp = q.ramp + 14'h0001;
              RAMP_DOWN: n.ramp = q.ramp - 14'h0001;
              RAMP_TRI:
              begin
                if (q.ramp_down)
                begin
                  n.ramp = q.ramp - 14'h0001;
                  n.ramp_down = (q.ramp != 14'h0001);
                end
                else
                begin
                  n.ramp = q.ramp + 14'h0001;
                  n.ramp_down = (q.ramp == RAMP_TOP - 14'h0001);
                end
              end
              default: n.ramp = '0;
            endcase
          end
          else
          begin
            n.step_cnt = q.step_cnt + 6'h01;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // automatic strobe timing
    if (q.sb_arm)
    begin
      if (q.sb_cnt == q.active[IX_SB_START])
      begin
        n.strobe_auto = 1'b1;
        n.sb_arm = 1'b0;
      end
      else
      begin
        n.sb_cnt = q.sb_cnt + 16'h0001;
      end
    end
    if (q.sp_arm)
    begin
      if (q.sp_cnt == q.active[IX_SB_CFG][SSTOP_LSB +: SSTOP_W])
      begin
        n.strobe_auto = 1'b0;
        n.sp_arm = 1'b0;
      end
      else
      begin
        n.sp_cnt = q.sp_cnt + 4'h1;
      end
    end
    if ((q.st == ST_IDLE) && trig_fall)
    begin
      n.sb_arm = 1'b1;
      n.sb_cnt = '0;
      n.sp_arm = 1'b0;
    end
    if (pat_done)
    begin
      n.sp_arm = 1'b1;
      n.sp_cnt = '0;
    end
    if (q.active[IX_SB_CFG][SMODE_BIT])
    begin
      n.pin = q.strobe_auto;
    end
    else
    begin
      n.pin = q.active[IX_SB_CFG][SVAL_BIT];
    end

    n.dac = wtpg_sat(scaled + off_ext);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q <= q_reset;
    end
    else
    begin
      q <= n;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign sdo_strobe_o = q.pin;
  assign sdo_strobe_oe_n_o = !strobe_enable_i;
  assign ram_addr_o = q.ram_addr;
  assign dac_data_o = q.dac;
  assign pattern_active_o = playing;
endmodule : wtpg_core
`default_nettype wire

// ==== verilog/wtpg_core_unused_guard.sv ====
`default_nettype none
`default_nettype wire

// ==== testbench/wtpg_core_checker.sv ====
`default_nettype none
module wtpg_core_checker
  import wtpg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  // strobe and converter
  input wire logic strobe_enable_i,
  input wire logic sdo_strobe_o,
  input wire logic sdo_strobe_oe_n_o,
  input wire logic [DAC_W-1:0] dac_data_o,
  input wire logic pattern_active_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic mapped;
  logic known;
  assign mapped = reg_addr_i inside {8'h20, 8'h25, 8'h27, 8'h28, 8'h29, 8'h2B, 8'h2C, 8'h2D,
    8'h31, 8'h35, 8'h37, 8'h5C};
  assign known = mapped || reg_addr_i inside {A_UPDATE, A_STATUS, 8'h1F};
  sequence s_upd;
    reg_wr_i && reg_addr_i == A_UPDATE && reg_wdata_i[UPD_BIT];
  endsequence
  sequence s_rd_upd;
    reg_rd_i && !reg_wr_i && reg_addr_i == A_UPDATE;
  endsequence
  property p_upd_clears;
    s_upd ##3 s_rd_upd |=> !reg_rdata_o[UPD_BIT];
  endproperty
  property p_oe;
    sdo_strobe_oe_n_o == !strobe_enable_i;
  endproperty
  property p_unmapped;
    reg_rd_i && !known |=> reg_rdata_o == 16'h0000;
  endproperty
  property p_rd_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  property p_rdback;
    reg_rd_i && !reg_wr_i && mapped && $past(reg_wr_i) && $past(reg_addr_i) == reg_addr_i
      |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  property p_status;
    reg_rd_i && reg_addr_i == A_STATUS |=> reg_rdata_o[15:2] == 14'h0000 && !reg_rdata_o[0];
  endproperty
  // writes feed the update path, so only a quiet stretch pins the offset-only level
  property p_idle_steady;
    (!pattern_active_o && !reg_wr_i) [*6] |-> $stable(dac_data_o);
  endproperty
  property p_reset_out;
    !$past(rst_n_i) |-> dac_data_o == 14'h0000 && !pattern_active_o && !sdo_strobe_o;
  endproperty
  a_upd_clears: assert property (p_upd_clears) else $error("update bit stuck");
  a_oe: assert property (p_oe) else $error("strobe pin enable wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_rdback: assert property (p_rdback) else $error("readback differs");
  a_status: assert property (p_status) else $error("status spare bits set");
  a_idle_steady: assert property (p_idle_steady) else $error("idle output moved");
  a_reset_out: assert property (p_reset_out) else $error("outputs not clear");
endmodule : wtpg_core_checker
bind wtpg_core wtpg_core_checker i_wtpg_core_checker (.ref_clk_i, .rst_n_i, .reg_wr_i,
  .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .strobe_enable_i, .sdo_strobe_o,
  .sdo_strobe_oe_n_o, .dac_data_o, .pattern_active_o);
`default_nettype wire

// ==== testbench/wtpg_host_model.sv ====
`default_nettype none
module wtpg_host_model
  import wtpg_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // register port
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  input wire logic [15:0] reg_rdata_i,
  // trigger and strobe enable
  output logic trigger_n_o,
  output logic strobe_enable_o,
  // pattern memory
  input wire logic [11:0] ram_addr_i,
  output logic [DAC_W-1:0] ram_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  assign ram_data_o = {ram_addr_i, ram_addr_i[1:0]};
  initial
  begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 16'h0000;
    trigger_n_o = 1'b1;
    strobe_enable_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b0;
    @(posedge ref_clk_i);
    #1 q = reg_rdata_i;
  endtask : rd
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    wr(a, d);
    reg_rd_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b0;
    @(posedge ref_clk_i);
    #1 q = reg_rdata_i;
  endtask : wr_rd
  // settings only reach the active set through this pulse
  task automatic update(output logic [15:0] q);
    wr(A_UPDATE, 16'h0001);
    @(posedge ref_clk_i);
    rd(A_UPDATE, q);
  endtask : update
  task automatic set_enable(input logic b);
    @(posedge ref_clk_i);
    strobe_enable_o <= b;
  endtask : set_enable
  task automatic fire();
    @(posedge ref_clk_i);
    trigger_n_o <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    trigger_n_o <= 1'b1;
  endtask : fire
endmodule : wtpg_host_model
`default_nettype wire

// ==== testbench/wtpg_core_test.sv ====
`default_nettype none
module wtpg_core_test
  import wtpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i, rst_n_i, reg_wr, reg_rd, trigger_n, strobe_enable;
  logic sdo_strobe, sdo_strobe_oe_n, pattern_active;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, q;
  logic [11:0] ram_addr, g, o, c;
  logic [DAC_W-1:0] ram_data, dds_data, chan_sum, dac_data, smp;
  logic [15:0] d, r, p, b, h, s, st, wave, len;
  logic [7:0] ra [10] = '{8'h25, 8'h27, 8'h28, 8'h29, 8'h2B, 8'h2C, 8'h2D, 8'h31, 8'h35, 8'h37};
  logic [15:0] rv [10] = '{16'h0000, 16'h0101, 16'h0111, 16'h8000, 16'h0101, 16'h0003,
    16'h0000, 16'h0000, 16'h0000, 16'h0104};
  logic [7:0] wa [13];
  logic [15:0] wd [13];
  int num_errors, samples_checked, cycles, seed;
  wtpg_core i_wtpg_core (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .trigger_n_i(trigger_n), .strobe_enable_i(strobe_enable), .sdo_strobe_o(sdo_strobe),
    .sdo_strobe_oe_n_o(sdo_strobe_oe_n), .ram_start_addr_i(12'h010), .ram_stop_addr_i(12'h01F),
    .ram_data_i(ram_data), .ram_addr_o(ram_addr), .dds_data_i(dds_data), .chan_sum_i(chan_sum),
    .dac_data_o(dac_data), .pattern_active_o(pattern_active));
  wtpg_host_model i_wtpg_host_model (.ref_clk_i(ref_clk_i), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata),
    .trigger_n_o(trigger_n), .strobe_enable_o(strobe_enable), .ram_addr_i(ram_addr),
    .ram_data_o(ram_data));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      close_out();
    end
  end
  // gain then offset, clamped to the converter range
  function automatic logic [DAC_W-1:0] exp_dac(input logic [DAC_W-1:0] sv, input logic [11:0] gv,
      input logic [11:0] ov);
    longint v;
    v = (longint'($signed(sv)) * longint'($signed(gv))) >>> 10;
    v = v + longint'($signed({ov, 2'b00}));
    v = (v > 8191) ? 8191 : ((v < -8192) ? -8192 : v);
    return v[DAC_W-1:0];
  endfunction : exp_dac
  task automatic run_pattern(input logic auto, input logic [DAC_W-1:0] exp);
    int n, t_up, t_dn, t_sup, t_sdn;
    logic [DAC_W-1:0] mid;
    t_up = -1;
    t_dn = -1;
    t_sup = -1;
    t_sdn = -1;
    mid = '0;
    i_wtpg_host_model.fire();
    n = 2;
    while (n < 900 && (t_dn < 0 || (auto && t_sdn < 0)))
    begin
      @(posedge ref_clk_i);
      #1 n++;
      if (pattern_active === 1'b1 && t_up < 0) t_up = n;
      if (pattern_active === 1'b0 && t_up >= 0 && t_dn < 0) t_dn = n;
      if (n == t_up + 2) mid = dac_data;
      if (sdo_strobe === 1'b1 && t_sup < 0) t_sup = n;
      if (sdo_strobe === 1'b0 && t_sup >= 0 && t_sdn < 0) t_sdn = n;
    end
    check(16'(t_up), d + 16'd4);
    check(16'(t_dn - t_up), len);
    check({2'b00, mid}, {2'b00, exp});
    if (auto)
    begin
      check(16'(t_sup), s + 16'd5);
      check(16'(t_sdn - t_dn), st + 16'd2);
    end
  endtask : run_pattern
  initial
  begin
    rst_n_i = 1'b0;
    dds_data = '0;
    chan_sum = '0;
    cycles = 0;
    num_errors = 0;
    samples_checked = 0;
    seed = $urandom(14);
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    check({2'b00, dac_data}, 16'h0000);
    foreach (ra[j])
    begin
      i_wtpg_host_model.rd(ra[j], q);
      check(q, rv[j]);
    end
    i_wtpg_host_model.rd(8'h40, q);
    check(q, 16'h0000);
    i_wtpg_host_model.rd(A_STATUS, q);
    check(q, 16'h0000);
    d = 16'($urandom);
    i_wtpg_host_model.wr_rd(8'h31, d, q);
    check(q, d);
    o = 12'($urandom);
    i_wtpg_host_model.wr(8'h25, {o, 4'h0});
    i_wtpg_host_model.update(q);
    check(q, 16'h0000);
    repeat (6) @(posedge ref_clk_i);
    check({2'b00, dac_data}, {2'b00, exp_dac(14'h0000, 12'h000, o)});
    i_wtpg_host_model.set_enable(1'b1);
    i_wtpg_host_model.wr(8'h2D, 16'h0020);
    i_wtpg_host_model.update(q);
    repeat (3) @(posedge ref_clk_i);
    check({15'h0, sdo_strobe}, 16'h0001);
    check({15'h0, sdo_strobe_oe_n}, 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      d = 16'($urandom_range(12));
      r = 16'($urandom_range(3));
      p = 16'(4 + $urandom_range(5));
      b = 16'($urandom_range(3));
      h = 16'(1 + $urandom_range(2));
      s = 16'($urandom_range(20));
      st = 16'($urandom_range(15));
      g = 12'($urandom);
      o = 12'($urandom);
      c = 12'($urandom);
      chan_sum <= 14'($urandom);
      dds_data <= 14'($urandom);
      len = (r + 16'd1) * p * (b + 16'd1);
      // strobe must rise before the pattern ends, or the stop count cannot drop it
      if (s >= d + len) s = d + len - 16'd1;
      wave = (k == 0) ? 16'h0101 : ((k == 1) ? 16'h0132 : ((k == 2) ? 16'h0111 : 16'h0100));
      // ram mode: hold of at least one keeps the start address for the sampled cycle
      smp = (k == 0) ? {c, 2'b00} : ((k == 3) ? 14'h0040 : 14'h0000);
      wa = '{8'h1F, 8'h20, 8'h2B, 8'h29, 8'h28, 8'h5C, 8'h27, 8'h31, 8'h35, 8'h25, 8'h37, 8'h2C,
        8'h2D};
      wd = '{16'h0001, d, r, p, {4'h0, h[3:0], b[3:0], 4'h0}, 16'h0000, wave, {c, 4'h0},
        {g, 4'h0}, {o, 4'h0}, 16'h0107, s, (k == 1) ? {12'h003, st[3:0]} : 16'h0000};
      foreach (wa[j]) i_wtpg_host_model.wr(wa[j], wd[j]);
      i_wtpg_host_model.update(q);
      repeat (3) @(posedge ref_clk_i);
      if (k == 1) smp = dds_data;
      if (k == 1) check({15'h0, sdo_strobe}, 16'h0000);
      run_pattern(k == 1, exp_dac(smp, g, o));
    end
    i_wtpg_host_model.set_enable(1'b0);
    @(posedge ref_clk_i);
    #1 check({15'h0, sdo_strobe_oe_n}, 16'h0001);
    close_out();
  end
endmodule : wtpg_core_test
`default_nettype wire
